// ==== hw/dram_pkg.sv ====
// Shared constants and carriers for the internal data RAM block
package dram_pkg;
   localparam int RAM_DEPTH = 256;
   localparam int ADDR_W = 8;
   localparam logic [7:0] DIRECT_LIMIT = 8'h80;
   localparam logic [15:0] AUX_TOP = 16'h00ff;
   localparam logic [7:0] SFR_UNLOCK_ADDR = 8'hf6;
   localparam logic [7:0] SFR_CTRL_ADDR = 8'hbf;
   localparam logic [7:0] KEY_FIRST = 8'h87;
   localparam logic [7:0] KEY_SECOND = 8'h59;
   localparam logic [7:0] KEY_CLOSE = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam int AUX_EN_BIT = 4;
   localparam int BANK_SHIFT = 3;

   typedef enum logic [1:0] {
      KIND_DIRECT = 2'b00,
      KIND_INDIRECT = 2'b01,
      KIND_XMOVE_INDEX = 2'b10,
      KIND_XMOVE_POINTER = 2'b11
   } dram_kind_e;

   typedef enum logic [1:0] {
      LOCK_CLOSED = 2'b00,
      LOCK_HALF = 2'b01,
      LOCK_OPEN = 2'b10
   } dram_lock_e;

   typedef struct packed {
      logic valid;
      dram_kind_e kind;
      logic write;
      logic index_sel;
      logic [1:0] bank;
      logic [7:0] addr;
      logic [15:0] data_pointer;
      logic [7:0] wdata;
   } dram_req_s;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
   } dram_rsp_s;

   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dram_ext_s;
endpackage

// ==== hw/dram_bank.sv ====
// One 256-byte synchronous RAM bank
`timescale 1ns/1ns
`default_nettype none
module dram_bank
   import dram_pkg::*;
(
   input wire logic clk,
   input wire logic en,
   input wire logic we,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [RAM_DEPTH];

   // ----------------------------------------
   // Write, or read held until the next read
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (en && !we) begin
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// ==== hw/dram_top.sv ====
// Data RAM decoder: scratchpad, auxiliary RAM, unlock key and external bus steering
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R01] Holds 512 bytes: a 256-byte scratchpad and a separate 256-byte auxiliary bank.
// [R02] Scratchpad below 80h reachable directly and through either index register.
// [R03] Scratchpad 80h and up reachable only indirectly; direct there never touches RAM.
// [R04] Auxiliary bank reached only by external-data moves via index register or data pointer.
// [R05] External-data moves above FFh run as ordinary external bus cycles.
// [R06] Any reset leaves the auxiliary bank disabled.
// [R07] Bit 4 of chip_control enables the auxiliary bank; clearing it disables it.
// [R08] With auxiliary enabled, index-register external-data moves always stay on chip.
// [R09] Auxiliary accesses leave port address, data and both strobes unchanged.
// [R10] Software writes key 87h then 59h to write_unlock_key before changing chip_control.
// [R11] write_unlock_key decodes at F6h and chip_control at BFh.
// [R12] chip_control writes ignored unless unlocked; writing zero to the key relocks.
module dram_top
   import dram_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire dram_req_s REQ,
   output logic REQ_READY,
   output dram_rsp_s RSP,
   output dram_ext_s EXT,
   input wire logic [7:0] EXT_RDATA,
   input wire logic EXT_ACK,
   output logic AUX_ENABLED
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_POINT = 3'b001,
      ST_ACCESS = 3'b010,
      ST_FINISH = 3'b011,
      ST_EXTWAIT = 3'b100
   } dram_state_e;

   logic rst_meta, rst_n;
   dram_state_e state, next_state;
   dram_req_s req_q;
   dram_lock_e lock;
   logic [7:0] chip_control;
   logic [7:0] eff_addr, scr_addr, scr_rdata, aux_rdata, sfr_rdata, ext_data_q;
   logic scr_en, scr_we, aux_en, go_ext, is_sfr, sfr_wr;
   logic [1:0] src_sel;

   function automatic logic sfr_write_to(input dram_req_s r, input logic [7:0] a);
      return r.kind == KIND_DIRECT && r.write && r.addr == a;
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign AUX_ENABLED = chip_control[AUX_EN_BIT]; // R07
   assign is_sfr = req_q.kind == KIND_DIRECT && req_q.addr >= DIRECT_LIMIT; // R03
   assign sfr_wr = state == ST_ACCESS && is_sfr && req_q.write;
   assign eff_addr = (req_q.kind == KIND_INDIRECT || req_q.kind == KIND_XMOVE_INDEX) ?
                     scr_rdata : (req_q.kind == KIND_XMOVE_POINTER ?
                     req_q.data_pointer[ADDR_W-1:0] : req_q.addr); // R02 R04

   always_comb begin
      scr_en = 1'b0;
      scr_we = 1'b0;
      scr_addr = eff_addr;
      aux_en = 1'b0;
      go_ext = 1'b0;
      if (state == ST_POINT) begin
         scr_en = 1'b1;
         scr_addr = ZERO_BYTE;
         scr_addr[BANK_SHIFT +: 2] = req_q.bank;
         scr_addr[0] = req_q.index_sel;
      end else if (state == ST_ACCESS) begin
         unique case (req_q.kind)
            KIND_DIRECT, KIND_INDIRECT: begin
               scr_en = !is_sfr; // R02 R03
               scr_we = req_q.write;
            end
            KIND_XMOVE_INDEX: begin
               aux_en = AUX_ENABLED; // R08
               go_ext = !AUX_ENABLED; // R06
            end
            KIND_XMOVE_POINTER: begin
               aux_en = AUX_ENABLED && req_q.data_pointer <= AUX_TOP; // R04
               go_ext = !aux_en; // R05
            end
         endcase
      end
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   dram_bank u_scratch ( // R01
      .clk(CLOCK),
      .en(scr_en),
      .we(scr_we),
      .addr(scr_addr),
      .wdata(req_q.wdata),
      .rdata(scr_rdata)
   );

   dram_bank u_aux ( // R01
      .clk(CLOCK),
      .en(aux_en),
      .we(req_q.write),
      .addr(eff_addr),
      .wdata(req_q.wdata),
      .rdata(aux_rdata)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   assign REQ_READY = state == ST_IDLE;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (REQ.valid) begin
               next_state = (REQ.kind == KIND_INDIRECT || REQ.kind == KIND_XMOVE_INDEX) ?
                            ST_POINT : ST_ACCESS;
            end
         end
         ST_POINT: next_state = ST_ACCESS;
         ST_ACCESS: next_state = go_ext ? ST_EXTWAIT : ST_FINISH;
         ST_FINISH: next_state = ST_IDLE;
         ST_EXTWAIT: next_state = EXT_ACK ? ST_FINISH : ST_EXTWAIT;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         req_q <= '0;
      end else if (state == ST_IDLE && REQ.valid) begin
         req_q <= REQ;
      end
   end

   // Remembers where the read data of this access comes from
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         src_sel <= 2'b00;
      end else if (state == ST_ACCESS) begin
         src_sel <= is_sfr ? 2'b10 : (aux_en ? 2'b01 : (go_ext ? 2'b11 : 2'b00));
      end
   end
   // ----------------------------------------
   // Unlock key and chip control
   // ----------------------------------------
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         lock <= LOCK_CLOSED;
      end else if (sfr_wr && req_q.addr == SFR_UNLOCK_ADDR) begin // R11
         if (req_q.wdata == KEY_FIRST) begin
            lock <= LOCK_HALF; // R10
         end else if (req_q.wdata == KEY_SECOND && lock == LOCK_HALF) begin
            lock <= LOCK_OPEN; // R10
         end else begin
            lock <= LOCK_CLOSED; // R12
         end
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         chip_control <= CTRL_RESET; // R06
      end else if (state == ST_ACCESS && sfr_write_to(req_q, SFR_CTRL_ADDR) &&
                   lock == LOCK_OPEN) begin // R11 R12
         chip_control <= req_q.wdata; // R07
      end
   end

   assign sfr_rdata = req_q.addr == SFR_CTRL_ADDR ? chip_control : ZERO_BYTE;

   // ----------------------------------------
   // External data bus
   // ----------------------------------------
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         EXT <= '{rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000, wdata: 8'h00};
      end else if (go_ext) begin // R05
         EXT.addr <= req_q.kind == KIND_XMOVE_POINTER ? req_q.data_pointer :
                     {8'h00, eff_addr};
         EXT.wdata <= req_q.wdata;
         EXT.rd_n <= req_q.write;
         EXT.wr_n <= !req_q.write;
      end else if (state == ST_EXTWAIT && EXT_ACK) begin
         EXT.rd_n <= 1'b1;
         EXT.wr_n <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ext_data_q <= ZERO_BYTE;
      end else if (state == ST_EXTWAIT && EXT_ACK) begin
         ext_data_q <= EXT_RDATA;
      end
   end

   // ----------------------------------------
   // Answer
   // ----------------------------------------
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         RSP <= '0;
      end else begin
         RSP.ack <= state == ST_FINISH;
         if (state == ST_FINISH && !req_q.write) begin
            unique case (src_sel)
               2'b00: RSP.rdata <= scr_rdata;
               2'b01: RSP.rdata <= aux_rdata;
               2'b10: RSP.rdata <= sfr_rdata;
               2'b11: RSP.rdata <= ext_data_q;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_direct_low: assert property (@(posedge CLOCK) disable iff (!rst_n) // R02
      state == ST_ACCESS && req_q.kind == KIND_DIRECT && req_q.addr < DIRECT_LIMIT
      |-> scr_en && scr_addr == req_q.addr)
      else $error("Low direct access missed scratchpad");
   a_direct_high: assert property (@(posedge CLOCK) disable iff (!rst_n) // R03
      state == ST_ACCESS && is_sfr |-> !scr_en && !aux_en ##1 src_sel == 2'b10)
      else $error("High direct access reached RAM");
   a_aux_only_move: assert property (@(posedge CLOCK) disable iff (!rst_n) // R04
      aux_en |-> state == ST_ACCESS && req_q.kind[1] && AUX_ENABLED)
      else $error("Auxiliary bank reached by other access");
   a_ext_high: assert property (@(posedge CLOCK) disable iff (!rst_n) // R05
      state == ST_ACCESS && req_q.kind == KIND_XMOVE_POINTER && req_q.data_pointer > AUX_TOP
      |=> state == ST_EXTWAIT && (!EXT.rd_n || !EXT.wr_n) && EXT.addr == $past(req_q.data_pointer))
      else $error("High external move not on bus");
   a_reset_off: assert property (@(posedge CLOCK) // R06
      !rst_n |=> !AUX_ENABLED)
      else $error("Auxiliary bank enabled after reset");
   a_ctrl_bit: assert property (@(posedge CLOCK) disable iff (!rst_n) // R07
      state == ST_ACCESS && sfr_write_to(req_q, SFR_CTRL_ADDR) && lock == LOCK_OPEN
      |=> AUX_ENABLED == $past(req_q.wdata[AUX_EN_BIT]))
      else $error("Enable bit not taken from write");
   a_index_aux: assert property (@(posedge CLOCK) disable iff (!rst_n) // R08
      state == ST_ACCESS && req_q.kind == KIND_XMOVE_INDEX && AUX_ENABLED
      |-> aux_en && !go_ext ##1 state == ST_FINISH ##1 RSP.ack)
      else $error("Index move left the chip");
   a_ports_hold: assert property (@(posedge CLOCK) disable iff (!rst_n) // R09
      aux_en |=> $stable(EXT.addr) && $stable(EXT.wdata) && EXT.rd_n && EXT.wr_n)
      else $error("Auxiliary access disturbed the ports");
   a_key_open: assert property (@(posedge CLOCK) disable iff (!rst_n) // R10
      sfr_wr && req_q.addr == SFR_UNLOCK_ADDR && req_q.wdata == KEY_SECOND && lock == LOCK_HALF
      |=> lock == LOCK_OPEN)
      else $error("Key sequence failed to unlock");
   a_ctrl_locked: assert property (@(posedge CLOCK) disable iff (!rst_n) // R12
      state == ST_ACCESS && lock != LOCK_OPEN |=> $stable(chip_control))
      else $error("Locked control register changed");
endmodule
`default_nettype wire

// ==== bench/dram_ext_mem.sv ====
// External data memory answering the strobed bus
`timescale 1ns/1ns
`default_nettype none
module dram_ext_mem
   import dram_pkg::*;
#(
   parameter int LAT = 2
)
(
   input wire logic CLOCK,
   input wire dram_ext_s EXT,
   output logic [7:0] EXT_RDATA,
   output logic EXT_ACK
);
   logic [7:0] mem [256];
   int cnt;
   // Ack after LAT waits, store on write
   always_ff @(posedge CLOCK) begin
      if (!EXT.rd_n || !EXT.wr_n) begin
         cnt <= cnt + 1;
         EXT_ACK <= (cnt >= LAT);
         if (cnt == LAT && !EXT.wr_n) mem[EXT.addr[7:0]] <= EXT.wdata;
      end else begin
         cnt <= 0;
         EXT_ACK <= 1'b0;
      end
   end
   // Bus shows inverted data whenever EXT_ACK is low
   assign EXT_RDATA = EXT_ACK ? mem[EXT.addr[7:0]] : ~mem[EXT.addr[7:0]];
endmodule
`default_nettype wire

// ==== bench/dram_top_tb_top.sv ====
// Testbench for the data RAM decoder
`timescale 1ns/1ns
`default_nettype none
module dram_top_tb_top
   import dram_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   dram_req_s req = '0;
   logic rdy, eack, aux;
   dram_rsp_s rsp;
   dram_ext_s ext;
   logic [7:0] erd, v;
   logic [15:0] xa;
   int miscompares = 0;
   int checked = 0;

   dram_top DUT (.CLOCK(clk), .RESETN(rst_n), .REQ(req), .REQ_READY(rdy), .RSP(rsp),
      .EXT(ext), .EXT_RDATA(erd), .EXT_ACK(eack), .AUX_ENABLED(aux));
   dram_ext_mem #(.LAT(2)) MEM (.CLOCK(clk), .EXT(ext), .EXT_RDATA(erd), .EXT_ACK(eack));

   initial begin
      forever #2 clk = ~clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic c, input string m);
      checked++;
      if (c !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask

   task automatic conclude;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic acc(input dram_kind_e k, input logic w, input logic [7:0] a,
         input logic [15:0] dp, input logic [7:0] wd, input logic x, input int lat,
         output logic [7:0] rd);
      dram_ext_s e0;
      int n;
      logic sx;
      e0 = ext;
      sx = 1'b0;
      @(posedge clk);
      req <= '{1'b1, k, w, a[0], a[2:1], a, dp, wd};
      @(posedge clk);
      req.valid <= 1'b0;
      for (n = 0; n < 50; n++) begin
         #1;
         if (n == 0) chk(rdy === 1'b0, "busy after take");
         if (!ext.rd_n || !ext.wr_n) begin
            sx = 1'b1;
            xa = ext.addr;
         end
         if (rsp.ack === 1'b1) break;
         @(posedge clk);
      end
      rd = rsp.rdata;
      chk(rdy === 1'b1, "ready with answer");
      chk(rsp.ack === 1'b1 && (lat < 0 || n == lat), "answer timing");
      chk(sx === x, "bus use");
      if (!x) chk(ext === e0, "port hold");
   endtask

   task automatic dw(input logic [7:0] a, input logic [7:0] d);
      acc(KIND_DIRECT, 1'b1, a, 16'h0, d, 1'b0, 2, v);
   endtask

   task automatic dr(input logic [7:0] a);
      acc(KIND_DIRECT, 1'b0, a, 16'h0, 8'h00, 1'b0, 2, v);
   endtask

   task automatic ctl(input logic [7:0] d);
      dw(8'hf6, 8'h87);
      dw(8'hf6, 8'h59);
      dw(8'hbf, d);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_lock;
      chk(aux === 1'b0, "aux after reset");
      dw(8'hbf, 8'h10);
      chk(aux === 1'b0, "locked write");
      dw(8'hf6, 8'h59);
      dw(8'hf6, 8'h87);
      dw(8'hbf, 8'h10);
      chk(aux === 1'b0, "half key");
      ctl(8'h10);
      chk(aux === 1'b1, "enable");
      dr(8'hbf);
      chk(v === 8'h10, "ctl read");
      dr(8'hf6);
      chk(v === 8'h00, "key read");
      dw(8'hf6, 8'h00);
      dw(8'hbf, 8'h00);
      chk(aux === 1'b1, "relock");
   endtask

   task automatic t_scratch;
      dw(8'h09, 8'h90);
      acc(KIND_INDIRECT, 1'b1, 8'h03, 16'h0, 8'h3c, 1'b0, 3, v);
      dr(8'h90);
      chk(v === 8'h00, "direct upper");
      dw(8'h90, 8'hff);
      acc(KIND_INDIRECT, 1'b0, 8'h03, 16'h0, 8'h00, 1'b0, 3, v);
      chk(v === 8'h3c, "indirect upper");
      dw(8'h12, 8'ha5);
      dw(8'h09, 8'h12);
      dw(8'h00, 8'h12);
      acc(KIND_INDIRECT, 1'b0, 8'h03, 16'h0, 8'h00, 1'b0, 3, v);
      chk(v === 8'ha5, "second index");
      acc(KIND_INDIRECT, 1'b0, 8'h00, 16'h0, 8'h00, 1'b0, 3, v);
      chk(v === 8'ha5, "first index");
   endtask

   task automatic t_aux;
      acc(KIND_XMOVE_INDEX, 1'b1, 8'h00, 16'h0, 8'h77, 1'b0, 3, v);
      acc(KIND_XMOVE_POINTER, 1'b0, 8'h00, 16'h0012, 8'h00, 1'b0, 2, v);
      chk(v === 8'h77, "aux read");
      dr(8'h12);
      chk(v === 8'ha5, "banks apart");
      acc(KIND_XMOVE_POINTER, 1'b1, 8'h00, 16'h0123, 8'hc3, 1'b1, -1, v);
      chk(xa === 16'h0123, "ext addr");
      acc(KIND_XMOVE_POINTER, 1'b0, 8'h00, 16'h0123, 8'h00, 1'b1, -1, v);
      chk(v === 8'hc3, "ext read");
      ctl(8'h00);
      chk(aux === 1'b0, "disable");
      acc(KIND_XMOVE_INDEX, 1'b1, 8'h00, 16'h0, 8'h5e, 1'b1, -1, v);
      chk(xa === 16'h0012, "index ext addr");
   endtask

   task automatic t_rst;
      ctl(8'h10);
      do_reset;
      chk(aux === 1'b0, "aux after reset");
      dw(8'h00, 8'h12);
      acc(KIND_XMOVE_INDEX, 1'b0, 8'h00, 16'h0, 8'h00, 1'b1, -1, v);
      chk(v === 8'h5e, "ext after reset");
   endtask

   initial begin
      do_reset;
      t_lock;
      t_scratch;
      t_aux;
      t_rst;
      conclude;
   end

   initial begin
      #40000;
      miscompares++;
      conclude;
   end
endmodule
`default_nettype wire
